// *** logic/lbm_pkg.sv ***
// Package for the lighting bus Manchester port: constants and carrier types
`default_nettype none
package lbm_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int PRESC_W = 10;
  localparam int TICKS_PER_HALF = 16;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 10'h0_000;
  // Half-bit counts at the default 2.4 kHz half-bit rate
  localparam real BIT_US = 833.33;
  localparam real FWD_GAP_MS = 9.17;
  localparam real BWD_MIN_MS = 2.92;
  localparam real BWD_MAX_MS = 9.17;
  localparam int BWD_MIN_HB = $rtoi((BWD_MIN_MS * 1000.0) / (BIT_US / 2.0)) + 1;
  localparam int BWD_MAX_HB = $rtoi((BWD_MAX_MS * 1000.0) / (BIT_US / 2.0));
  localparam int IDLE_HB = 4;
  localparam int WDG_MS = 500;
  localparam int WDG_CYC = WDG_MS * (CLK_HZ / 1000);
  localparam int FIFO_DEPTH = 8;
  localparam int FLT_DIV_W = 8;
  localparam int FLT_CNT_W = 6;
  localparam logic [4:0] BODY_16 = 5'h10;
  localparam logic [4:0] BODY_17 = 5'h11;
  localparam logic [4:0] BODY_18 = 5'h12;
  localparam logic [4:0] BODY_24 = 5'h18;

  typedef enum logic [1:0]
  {
    LEN_16 = 2'b00,
    LEN_17 = 2'b01,
    LEN_18 = 2'b10,
    LEN_24 = 2'b11
  } lbm_len_t;

  typedef enum logic [1:0]
  {
    FLT_DEBOUNCE = 2'b00,
    FLT_GLITCH = 2'b01,
    FLT_RETRIG = 2'b10,
    FLT_OFF = 2'b11
  } lbm_flt_mode_t;

  typedef struct packed
  {
    logic enable;
    logic [2:0] src_sel;
    logic [FLT_DIV_W-1:0] div;
    lbm_flt_mode_t mode;
    logic [FLT_CNT_W-1:0] count;
  } lbm_flt_cfg_t;

  typedef struct packed
  {
    logic [PRESC_W-1:0] rate_prescaler;
    lbm_len_t length;
    logic rx_invert;
    logic tx_invert;
    logic start_mask_select;
    logic frame_irq_en;
    logic hang_irq_en;
  } lbm_cfg_t;
endpackage
`default_nettype wire

// *** logic/lbm_fifo.sv ***
// Parameterised flip-flop FIFO with valid/ready on both sides
`default_nettype none
module lbm_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;

  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** logic/lbm_filter.sv ***
// Receive-line noise filter: fast sampler, prescaled tick, three filter modes plus off
`default_nettype none
module lbm_filter
  import lbm_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic fast_clk,
  input wire logic [7:0] src_clocks,
  input wire logic pin_in,
  input wire lbm_pkg::lbm_flt_cfg_t cfg,
  output logic filt_out
);
  // Pin sampled on the fast clock before anything reads it
  logic s1_q;
  logic s2_q;
  always_ff @(posedge fast_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end

  // Fast-sampled level moved into the system domain
  logic m1_q;
  logic m2_q;
  logic src1_q;
  logic src2_q;
  logic src3_q;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      m1_q <= 1'b1;
      m2_q <= 1'b1;
      src1_q <= 1'b0;
      src2_q <= 1'b0;
      src3_q <= 1'b0;
    end
    else
    begin
      m1_q <= s2_q;
      m2_q <= m1_q;
      src1_q <= src_clocks[cfg.src_sel];
      src2_q <= src1_q;
      src3_q <= src2_q;
    end
  end

  // Tick from selected source edge through the 8-bit prescaler
  logic [FLT_DIV_W-1:0] div_q;
  logic tick;
  assign tick = clk_en && src2_q && !src3_q && (div_q == cfg.div);
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      div_q <= '0;
    else if (clk_en && src2_q && !src3_q)
      div_q <= (div_q == cfg.div) ? '0 : div_q + 1'b1;
  end

  logic out_q;
  logic old_q;
  logic busy_q;
  logic [FLT_CNT_W:0] per_q;
  logic prev_q;
  logic change;
  logic done;
  assign change = (m2_q != prev_q);
  // Period is count plus two ticks, giving the documented delay spread
  assign done = tick && (per_q == {1'b0, cfg.count} + 7'h0_01);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_q <= 1'b1;
      old_q <= 1'b1;
      busy_q <= 1'b0;
      per_q <= '0;
      prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      prev_q <= m2_q;
      if (busy_q && tick)
        per_q <= per_q + 1'b1;
      unique case (cfg.mode)
        FLT_DEBOUNCE:
        begin
          if (!busy_q && m2_q != out_q)
          begin
            out_q <= m2_q;
            busy_q <= 1'b1;
            per_q <= '0;
          end
          else if (done)
            busy_q <= 1'b0;
        end
        FLT_GLITCH:
        begin
          if (!busy_q && m2_q != out_q)
          begin
            old_q <= out_q;
            busy_q <= 1'b1;
            per_q <= '0;
          end
          else if (done)
          begin
            busy_q <= 1'b0;
            if (m2_q != old_q)
              out_q <= m2_q;
          end
        end
        FLT_RETRIG:
        begin
          if (change)
          begin
            busy_q <= 1'b1;
            per_q <= '0;
          end
          else if (done)
          begin
            busy_q <= 1'b0;
            out_q <= m2_q;
          end
        end
        FLT_OFF:
        begin
          out_q <= m2_q;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign filt_out = cfg.enable ? out_q : m2_q;
endmodule
`default_nettype wire

// *** logic/lbm_port.sv ***
// Lighting bus Manchester port: receiver, transmitter, settling timers, watchdog
`default_nettype none
module lbm_port
  import lbm_pkg::*;
#(
  parameter int WDG_CYCLES = WDG_CYC,
  parameter int FDEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic fast_clk,
  input wire logic [7:0] filter_source_clocks,
  input wire lbm_pkg::lbm_cfg_t cfg,
  input wire lbm_pkg::lbm_flt_cfg_t flt_cfg,
  input wire logic bus_receive_line,
  output logic bus_transmit_line,
  output logic [23:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic flag_clear,
  output logic frame_event_flag,
  output logic code_error_flag,
  output logic line_hang_flag,
  output logic no_reply_status,
  output logic idle_elapsed_status,
  output logic irq
);
  typedef enum logic [2:0]
  {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_BIT = 3'b010,
    RX_STOP = 3'b011,
    RX_WAIT = 3'b100
  } lbm_rx_state_t;

  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_GAP = 2'b01,
    TX_SEND = 2'b10
  } lbm_tx_state_t;

  // Filter stage on the receive pin
  logic rx_filt;
  lbm_filter u_filter (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .fast_clk(fast_clk),
    .src_clocks(filter_source_clocks),
    .pin_in(bus_receive_line),
    .cfg(flt_cfg),
    .filt_out(rx_filt)
  );
  logic rx_lvl;
  assign rx_lvl = rx_filt ^ cfg.rx_invert;

  // Rate tick: sixteen sub-ticks per half-bit, each N+1 clocks
  logic [PRESC_W-1:0] pre_q;
  logic [3:0] sub_q;
  logic sub_tick;
  logic hb_tick;
  assign sub_tick = clk_en && (pre_q == cfg.rate_prescaler);
  assign hb_tick = sub_tick && (sub_q == 4'(TICKS_PER_HALF - 1));
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_q <= PRESC_RESET;
      sub_q <= '0;
    end
    else if (clk_en)
    begin
      pre_q <= sub_tick ? '0 : pre_q + 1'b1;
      if (sub_tick)
        sub_q <= sub_q + 1'b1;
    end
  end

  logic [4:0] body_len;
  always_comb
  begin
    unique case (cfg.length)
      LEN_16: body_len = BODY_16;
      LEN_17: body_len = BODY_17;
      LEN_18: body_len = BODY_18;
      LEN_24: body_len = BODY_24;
    endcase
  end

  // Receiver samples at sub-tick rate; half boundaries found by edges
  lbm_rx_state_t rx_q;
  logic prev_rx_q;
  logic [5:0] ph_q;
  logic [2:0] idle_q;
  logic [4:0] nbits_q;
  logic [23:0] shift_q;
  logic first_q;
  logic rx_push;
  logic rx_err;
  logic [23:0] rx_word;
  logic fifo_in_ready;
  logic rx_edge;
  assign rx_edge = (rx_lvl != prev_rx_q);
  localparam logic [4:0] HALF_MIN = 5'h0_0A;
  localparam logic [4:0] HALF_MAX = 5'h0_16;
  localparam logic [4:0] FULL_MIN = 5'h0_1B;
  // Data can hold one level for two halves, so only a longer quiet spell ends the body
  localparam logic [5:0] FULL_MAX = 6'h2_5;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_q <= RX_IDLE;
      prev_rx_q <= 1'b1;
      ph_q <= '0;
      idle_q <= '0;
      nbits_q <= '0;
      shift_q <= '0;
      first_q <= 1'b0;
      rx_push <= 1'b0;
      rx_err <= 1'b0;
      rx_word <= '0;
    end
    else if (clk_en)
    begin
      rx_push <= 1'b0;
      rx_err <= 1'b0;
      prev_rx_q <= rx_lvl;
      if (sub_tick && ph_q != 6'h3_F)
        ph_q <= ph_q + 1'b1;
      if (!rx_lvl)
        idle_q <= '0;
      else if (hb_tick && idle_q != 3'(IDLE_HB))
        idle_q <= idle_q + 1'b1;
      unique case (rx_q)
        RX_IDLE:
          if (rx_edge && !rx_lvl && (idle_q == 3'(IDLE_HB) || !cfg.start_mask_select))
          begin
            rx_q <= RX_START;
            ph_q <= '0;
          end
        RX_START:
          if (rx_edge)
          begin
            // Short low tolerated when waking from halt
            if (ph_q >= HALF_MIN || !cfg.start_mask_select)
            begin
              rx_q <= RX_BIT;
              ph_q <= '0;
              nbits_q <= '0;
              first_q <= 1'b1;
              shift_q <= '0;
            end
            else
            begin
              rx_q <= RX_WAIT;
              rx_err <= 1'b1;
            end
          end
          else if (ph_q > HALF_MAX)
          begin
            rx_q <= RX_WAIT;
            rx_err <= 1'b1;
          end
        RX_BIT:
          // Mid-bit edges carry data; boundary edges fall at half spacing
          if (rx_edge)
          begin
            if (ph_q >= FULL_MIN || (ph_q >= HALF_MIN && ph_q <= HALF_MAX && !first_q))
            begin
              shift_q <= {shift_q[22:0], rx_lvl};
              nbits_q <= nbits_q + 1'b1;
              first_q <= 1'b1;
              ph_q <= '0;
            end
            else if (ph_q >= HALF_MIN && ph_q <= HALF_MAX)
            begin
              first_q <= 1'b0;
              ph_q <= '0;
            end
            else
            begin
              rx_q <= RX_WAIT;
              rx_err <= 1'b1;
            end
          end
          else if (ph_q > FULL_MAX && rx_lvl)
            rx_q <= RX_STOP;
          else if (ph_q > FULL_MAX)
          begin
            rx_q <= RX_WAIT;
            rx_err <= 1'b1;
          end
        RX_STOP:
          begin
            if (nbits_q == body_len)
            begin
              rx_push <= 1'b1;
              rx_word <= shift_q;
            end
            else
              rx_err <= 1'b1;
            rx_q <= RX_WAIT;
          end
        RX_WAIT:
          if (idle_q == 3'(IDLE_HB))
            rx_q <= RX_IDLE;
      endcase
    end
  end

  // Received words queue toward the consumer; a full queue drops the frame
  lbm_fifo #(.WIDTH(24), .DEPTH(FDEPTH)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign idle_elapsed_status = (rx_q == RX_IDLE) && (idle_q == 3'(IDLE_HB));

  // Backward frame transmitter with settling window
  lbm_tx_state_t tx_q;
  logic [7:0] gap_q;
  logic [4:0] slot_q;
  logic [21:0] tx_sr_q;
  logic tx_line_q;
  logic tx_done;
  assign tx_ready = (tx_q == TX_GAP) && (gap_q >= 8'(BWD_MIN_HB));
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_q <= TX_IDLE;
      gap_q <= '0;
      slot_q <= '0;
      tx_sr_q <= '1;
      tx_line_q <= 1'b1;
      tx_done <= 1'b0;
      no_reply_status <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_done <= 1'b0;
      unique case (tx_q)
        TX_IDLE:
          if (rx_push)
          begin
            tx_q <= TX_GAP;
            gap_q <= '0;
            no_reply_status <= 1'b0;
          end
        TX_GAP:
          if (tx_valid && tx_ready)
          begin
            // Start one, eight Manchester data bits, four high stop halves
            tx_sr_q <= {2'b01,
              ~tx_data[7], tx_data[7], ~tx_data[6], tx_data[6],
              ~tx_data[5], tx_data[5], ~tx_data[4], tx_data[4],
              ~tx_data[3], tx_data[3], ~tx_data[2], tx_data[2],
              ~tx_data[1], tx_data[1], ~tx_data[0], tx_data[0],
              4'hF};
            slot_q <= '0;
            tx_q <= TX_SEND;
          end
          else if (hb_tick)
          begin
            if (gap_q == 8'(BWD_MAX_HB))
            begin
              tx_q <= TX_IDLE;
              no_reply_status <= 1'b1;
            end
            else
              gap_q <= gap_q + 1'b1;
          end
        TX_SEND:
          if (hb_tick)
          begin
            tx_line_q <= tx_sr_q[21];
            tx_sr_q <= {tx_sr_q[20:0], 1'b1};
            slot_q <= slot_q + 1'b1;
            if (slot_q == 5'h1_6)
            begin
              tx_q <= TX_IDLE;
              tx_done <= 1'b1;
            end
          end
      endcase
    end
  end
  assign bus_transmit_line = tx_line_q ^ cfg.tx_invert;

  // Watchdog on a receive line held away from idle
  logic [$clog2(WDG_CYCLES+1)-1:0] wdg_q;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wdg_q <= '0;
    else if (clk_en)
    begin
      if (rx_lvl)
        wdg_q <= '0;
      else if (wdg_q != WDG_CYCLES)
        wdg_q <= wdg_q + 1'b1;
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_event_flag <= 1'b0;
      code_error_flag <= 1'b0;
      line_hang_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_event_flag <= (rx_push || tx_done) || (frame_event_flag && !flag_clear);
      code_error_flag <= rx_err || (code_error_flag && !flag_clear);
      line_hang_flag <= (wdg_q == WDG_CYCLES - 1) || (line_hang_flag && !flag_clear);
    end
  end
  assign irq = (frame_event_flag && cfg.frame_irq_en) || (line_hang_flag && cfg.hang_irq_en);
endmodule
`default_nettype wire

// *** tb/lbm_port_asserts.sv ***
// Concurrent checks on the lighting bus port pins
`default_nettype none
module lbm_port_asserts
  import lbm_pkg::*;
#(
  parameter int WDG_CYCLES = WDG_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire lbm_pkg::lbm_cfg_t cfg,
  input wire logic bus_receive_line,
  input wire logic bus_transmit_line,
  input wire logic [23:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic flag_clear,
  input wire logic frame_event_flag,
  input wire logic code_error_flag,
  input wire logic line_hang_flag,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  int hb_cyc;
  int since_rx_q;
  int since_tx_q;
  int low_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  assign hb_cyc = 16 * (int'(cfg.rate_prescaler) + 1);
  // since_rx_q and since_tx_q start saturated so nothing fires before the first frame; low_q starts at zero
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) since_rx_q <= 1_000_000;
    else if ($rose(rx_valid)) since_rx_q <= 0;
    else if (since_rx_q < 1_000_000) since_rx_q <= since_rx_q + 1;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) since_tx_q <= 1_000_000;
    else if (tx_valid && tx_ready) since_tx_q <= 0;
    else if (since_tx_q < 1_000_000) since_tx_q <= since_tx_q + 1;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) low_q <= 0;
    else low_q <= (bus_receive_line == cfg.rx_invert) ? low_q + 1 : 0;

  chk_tx_idle_reset: assert property ($rose(reset_n) |-> bus_transmit_line == !cfg.tx_invert)
    else $error("transmit line not idle after reset");
  chk_rx_data_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive word changed while stalled");
  chk_irq_mask: assert property (irq == ((frame_event_flag && cfg.frame_irq_en)
    || (line_hang_flag && cfg.hang_irq_en)))
    else $error("request line disagrees with masked flags");
  chk_err_fall_cause: assert property ($fell(code_error_flag) |-> $past(flag_clear))
    else $error("error flag dropped without clear");
  chk_hang_fall_cause: assert property ($fell(line_hang_flag) |-> $past(flag_clear))
    else $error("hang flag dropped without clear");
  chk_hang_timer: assert property (low_q == WDG_CYCLES + 16 |-> line_hang_flag)
    else $error("hung line not flagged");
  chk_event_push: assert property ($rose(rx_valid) |-> ##[0:4] frame_event_flag)
    else $error("delivered frame without event flag");
  chk_err_no_push: assert property ($rose(code_error_flag) |-> ##1 (!$rose(rx_valid)) [*4])
    else $error("bad frame was delivered");
  chk_tx_active_window: assert property (bus_transmit_line == cfg.tx_invert
    && $stable(cfg.tx_invert) |-> since_tx_q <= 24 * hb_cyc + 8)
    else $error("transmit line active outside a reply");
  chk_ready_not_early: assert property ($rose(tx_ready) |-> since_rx_q >= (BWD_MIN_HB - 1) * hb_cyc)
    else $error("reply window opened early");
  cover property ($rose(rx_valid));
  cover property (tx_valid && tx_ready);
  cover property ($rose(line_hang_flag));
endmodule
bind lbm_port lbm_port_asserts #(.WDG_CYCLES(WDG_CYCLES)) u_chk (
  .clock(clock), .reset_n(reset_n), .cfg(cfg), .bus_receive_line(bus_receive_line),
  .bus_transmit_line(bus_transmit_line), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .flag_clear(flag_clear),
  .frame_event_flag(frame_event_flag), .code_error_flag(code_error_flag),
  .line_hang_flag(line_hang_flag), .irq(irq));
`default_nettype wire

// *** tb/lbm_ctrl_model.sv ***
// Behavioural bus controller: sends forward frames, decodes backward frames
`default_nettype none
module lbm_ctrl_model (
  input wire logic clock,
  input var int hb,
  input wire logic inv_out,
  input wire logic inv_in,
  input wire logic bus_transmit_line,
  output logic bus_receive_line,
  output logic back_done,
  output logic [7:0] back_byte,
  output var int back_gap
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int end_cyc = -100000;
  logic lvl = 1'b1;
  logic busy = 1'b0;
  assign bus_receive_line = lvl ^ inv_out;
  initial back_done = 1'b0;
  always @(negedge clock) cyc <= cyc + 1;
  task automatic half(input logic v, input int n);
    lvl = v;
    repeat (n) @(negedge clock);
  endtask
  // Mode 1 holds one bit's first level for three halves, mode 2 shortens the start low phase
  task automatic send(input logic [23:0] body, input int n, input int mode);
    while (cyc - end_cyc < 22 * hb) @(negedge clock);
    half(1'b0, (mode == 2) ? hb / 4 : hb);
    half(1'b1, hb);
    for (int i = n - 1; i >= 0; i--)
    begin
      half(~body[i], hb);
      half((mode == 1 && i == n - 3) ? ~body[i] : body[i],
        (mode == 1 && i == n - 3) ? 2 * hb : hb);
    end
    half(1'b1, 4 * hb);
    end_cyc = cyc;
  endtask
  // Samples the middle of each second half, where the bit value sits
  task automatic decode();
    busy = 1'b1;
    back_gap = cyc - end_cyc;
    repeat (hb + hb / 2) @(negedge clock);
    for (int k = 0; k < 8; k++)
    begin
      repeat (2 * hb) @(negedge clock);
      back_byte = {back_byte[6:0], bus_transmit_line ^ inv_in};
    end
    back_done = 1'b1;
    @(negedge clock);
    back_done = 1'b0;
    repeat (3 * hb) @(negedge clock);
    busy = 1'b0;
  endtask
  always @(negedge clock)
    if (!busy && bus_transmit_line === inv_in)
      decode();
endmodule
`default_nettype wire

// *** tb/test_lighting_bus_manchester_port.sv ***
// Self-checking bench for the lighting bus Manchester port
`default_nettype none
module test_lighting_bus_manchester_port;
  timeunit 1ns;
  timeprecision 1ps;
  import lbm_pkg::*;
  localparam int WDG = 1000;
  logic clock = 1'b0;
  logic fast_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] src_clk = 8'h00;
  lbm_cfg_t cfg;
  lbm_flt_cfg_t flt_cfg;
  logic rx_ready = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic flag_clear = 1'b0;
  logic rx_line, tx_line, rx_valid, tx_ready, ev_f, err_f, hang_f, no_reply, idle_ok, irq;
  logic [23:0] rx_data;
  logic back_done;
  logic [7:0] back_byte;
  int back_gap;
  int hb = 16;
  int errors = 0;
  int num_checks = 0;
  logic [23:0] exp_rx[$];
  logic [7:0] exp_tx[$];
  int lens[4] = '{16, 17, 18, 24};
  logic [9:0] rates[3] = '{10'h000, 10'h001, 10'h003};

  initial forever #2 clock = ~clock;
  initial forever #5.208 fast_clk = ~fast_clk;
  always @(posedge clock) src_clk <= src_clk + 8'h01;

  lbm_port #(.WDG_CYCLES(WDG), .FDEPTH(FIFO_DEPTH)) dut (
    .clock(clock), .reset_n(reset_n), .clk_en(1'b1), .fast_clk(fast_clk),
    .filter_source_clocks(src_clk), .cfg(cfg), .flt_cfg(flt_cfg), .bus_receive_line(rx_line),
    .bus_transmit_line(tx_line), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .flag_clear(flag_clear),
    .frame_event_flag(ev_f), .code_error_flag(err_f), .line_hang_flag(hang_f),
    .no_reply_status(no_reply), .idle_elapsed_status(idle_ok), .irq(irq));
  lbm_ctrl_model ctrl (.clock(clock), .hb(hb), .inv_out(cfg.rx_invert), .inv_in(cfg.tx_invert),
    .bus_transmit_line(tx_line), .bus_receive_line(rx_line), .back_done(back_done),
    .back_byte(back_byte), .back_gap(back_gap));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    cycles(2);
    reset_n = 1'b1;
    hb = 16 * (int'(cfg.rate_prescaler) + 1);
    cycles(5 * hb);
  endtask
  task automatic clear();
    flag_clear = 1'b1;
    cycles(1);
    flag_clear = 1'b0;
    cycles(1);
    check({ev_f, err_f, hang_f}, 3'h0);
  endtask
  task automatic fwd(input int n, input int mode, input logic keep);
    logic [23:0] body;
    body = 24'($urandom() & ((1 << n) - 1));
    if (keep)
      exp_rx.push_back(body);
    ctrl.send(body, n, mode);
    cycles(6);
  endtask
  task automatic back();
    int w;
    cycles(2 * hb);
    check(tx_ready, 1'b0);
    w = 0;
    while (tx_ready !== 1'b1 && w < 30 * hb)
    begin
      cycles(1);
      w++;
    end
    tx_data = 8'($urandom());
    exp_tx.push_back(tx_data);
    tx_valid = 1'b1;
    @(posedge clock);
    @(negedge clock);
    tx_valid = 1'b0;
    cycles(30 * hb);
  endtask

  always @(posedge clock)
    if (rx_valid && rx_ready)
      check(rx_data, (exp_rx.size() > 0) ? exp_rx.pop_front() : 24'hxx_xxxx);
  always @(posedge clock)
    if (back_done === 1'b1)
    begin
      check(back_byte, (exp_tx.size() > 0) ? exp_tx.pop_front() : 8'hxx);
      check(back_gap >= (BWD_MIN_HB - 4) * hb && back_gap <= (BWD_MAX_HB + 2) * hb, 1'b1);
    end

  initial
  begin
    int w;
    void'($urandom(6707));
    cfg = '{rate_prescaler: 10'h000, length: LEN_16, rx_invert: 1'b0, tx_invert: 1'b0,
      start_mask_select: 1'b1, frame_irq_en: 1'b1, hang_irq_en: 1'b1};
    flt_cfg = '{enable: 1'b0, src_sel: 3'h0, div: 8'h00, mode: FLT_OFF, count: 6'h00};
    do_reset();
    check({tx_line, ev_f, err_f, hang_f, rx_valid}, 5'h10);
    check(idle_ok, 1'b1);
    $display("test reset done");
    for (int l = 0; l < 4; l++)
    begin
      cfg.length = lbm_len_t'(l);
      do_reset();
      fwd(lens[l], 0, 1'b1);
      check({ev_f, irq}, 2'h3);
      cycles(24 * hb);
      check(no_reply, 1'b1);
      clear();
    end
    $display("test lengths done");
    cfg.length = LEN_16;
    foreach (rates[i])
    begin
      cfg.rate_prescaler = rates[i];
      do_reset();
      fwd(16, 0, 1'b1);
      back();
      clear();
    end
    $display("test rates done");
    cfg.rate_prescaler = 10'h000;
    cfg.length = LEN_17;
    do_reset();
    fwd(16, 0, 1'b0);
    check(err_f, 1'b1);
    clear();
    fwd(17, 1, 1'b0);
    check(err_f, 1'b1);
    clear();
    fwd(17, 0, 1'b1);
    clear();
    $display("test errors done");
    for (int p = 1; p < 3; p++)
    begin
      cfg.rx_invert = p[0];
      cfg.tx_invert = p[1];
      do_reset();
      check(tx_line, !p[1]);
      fwd(17, 0, 1'b1);
      back();
      clear();
    end
    $display("test polarity done");
    cfg.rx_invert = 1'b0;
    cfg.tx_invert = 1'b0;
    cfg.start_mask_select = 1'b0;
    do_reset();
    fwd(17, 2, 1'b1);
    clear();
    $display("test short start done");
    for (int m = 0; m < 3; m++)
    begin
      flt_cfg = '{enable: 1'b1, src_sel: 3'h0, div: 8'h00, mode: lbm_flt_mode_t'(m),
        count: 6'($urandom_range(2, 0))};
      fwd(17, 0, 1'b1);
    end
    flt_cfg.enable = 1'b0;
    clear();
    $display("test filter done");
    ctrl.half(1'b0, WDG + 100);
    check({hang_f, irq}, 2'h3);
    cfg.hang_irq_en = 1'b0;
    cycles(1);
    check(irq, 1'b0);
    ctrl.half(1'b1, 8 * hb);
    clear();
    $display("test watchdog done");
    // Stalled reader: the ninth word finds the buffer full and is dropped
    rx_ready = 1'b0;
    for (int f = 0; f <= FIFO_DEPTH; f++)
      fwd(17, 0, f < FIFO_DEPTH);
    check(rx_valid, 1'b1);
    w = 0;
    while (exp_rx.size() > 0 && w < 1000)
    begin
      rx_ready = 1'($urandom());
      cycles(1);
      w++;
    end
    rx_ready = 1'b1;
    cycles(4);
    check(rx_valid, 1'b0);
    $display("test buffer done");
    check(24'(exp_rx.size() + exp_tx.size()), 24'h00_0000);
    report_and_stop();
  end
  // About 33000 cycles are expected; the limit allows 100000
  initial
  begin
    #400_000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
